//--- include/scroll_regs_pkg.sv
// Package for the screen block start address and line count register group.
// Assumes an 8-bit register port with a register index and one host clock.
package scroll_regs_pkg;
  localparam logic [7:0] IDX_B1_LOW = 8'h0B;
  localparam logic [7:0] IDX_B1_HIGH = 8'h0C;
  localparam logic [7:0] IDX_B1_LINES = 8'h0D;
  localparam logic [7:0] IDX_B2_LOW = 8'h0E;
  localparam logic [7:0] IDX_B2_HIGH = 8'h0F;
  localparam logic [7:0] IDX_B2_LINES = 8'h10;
  localparam logic [7:0] IDX_B3_LOW = 8'h11;
  localparam logic [7:0] IDX_B3_HIGH = 8'h12;
  localparam logic [7:0] IDX_B4_LOW = 8'h13;
  localparam logic [7:0] IDX_B4_HIGH = 8'h14;
  localparam logic [7:0] SCROLL_PARAM_COUNT = 8'h0A;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [8:0] LINES_RESET = 9'h001;
  localparam logic [8:0] LINE_COUNT_BIAS = 9'h001;

  typedef enum logic [0:0] {
    INTAKE_IDLE = 1'b0,
    INTAKE_LOAD = 1'b1
  } intake_type;

  typedef struct packed {
    logic [7:0] low_staged;
    logic [7:0] high;
    logic [15:0] start_addr;
  } block_addr_type;

  localparam block_addr_type BLOCK_RESET = '{low_staged: REG_RESET, high: REG_RESET, start_addr: ADDR_RESET};

  typedef struct packed {
    block_addr_type [3:0] blk;
    logic [7:0] lines1;
    logic [7:0] lines2;
    logic [8:0] lines1_count;
    logic [8:0] lines2_count;
    logic [7:0] rdata;
    logic [7:0] param_idx;
    intake_type intake;
  } state_type;

  localparam state_type STATE_RESET = '{
    blk: {4{BLOCK_RESET}},
    lines1: REG_RESET,
    lines2: REG_RESET,
    lines1_count: LINES_RESET,
    lines2_count: LINES_RESET,
    rdata: REG_RESET,
    param_idx: REG_RESET,
    intake: INTAKE_IDLE
  };
endpackage

//--- design/scroll_regs.sv
// Screen block start address and line count registers with SCROLL parameter intake.
// Assumes single-cycle write and read strobes from a host interface on I_SYS_CLK.
`timescale 1ns/1ps
module scroll_regs
  import scroll_regs_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_SYS_RST,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_index,
  input wire logic [7:0] i_wdata,
  input wire logic i_scroll_cmd,
  input wire logic i_param_wr,
  output logic [7:0] O_RDATA,
  output logic [15:0] O_BLOCK1_START_ADDR,
  output logic [15:0] O_BLOCK2_START_ADDR,
  output logic [15:0] O_BLOCK3_START_ADDR,
  output logic [15:0] O_BLOCK4_START_ADDR,
  output logic [8:0] O_BLOCK1_LINES,
  output logic [8:0] O_BLOCK2_LINES,
  output logic O_SCROLL_ACTIVE
);
  state_type state_reg;
  state_type state_next;
  logic [7:0] tgt_idx;
  logic tgt_wr;

  // Next state: parameter intake, at most one register write, one registered read
  always_comb
  begin
    state_next = state_reg;
    tgt_wr = 1'b0;
    tgt_idx = i_index;
    // The command strobe wins over a parameter byte or a direct write in the same cycle
    case (state_reg.intake)
      INTAKE_IDLE:
      begin
        if (i_scroll_cmd)
        begin
          state_next.intake = INTAKE_LOAD;
          state_next.param_idx = REG_RESET;
        end
        else if (i_wr)
        begin
          tgt_wr = 1'b1;
        end
      end
      INTAKE_LOAD:
      begin
        // A new command restarts intake at the first register
        if (i_scroll_cmd)
        begin
          state_next.param_idx = REG_RESET;
        end
        else if (i_param_wr)
        begin
          tgt_wr = 1'b1;
          tgt_idx = 8'(IDX_B1_LOW + state_reg.param_idx);
          state_next.param_idx = 8'(state_reg.param_idx + 8'h01);
          if (state_reg.param_idx == 8'(SCROLL_PARAM_COUNT - 8'h01))
          begin
            state_next.intake = INTAKE_IDLE;
          end
        end
        else if (i_wr)
        begin
          tgt_wr = 1'b1;
          // Direct writes abandon a partly loaded parameter list
          state_next.intake = INTAKE_IDLE;
        end
      end
      default:
      begin
        state_next.intake = INTAKE_IDLE;
      end
    endcase

    // Low bytes only stage; the high byte write moves both into the live address
    if (tgt_wr)
    begin
      case (tgt_idx)
        IDX_B1_LOW:
        begin
          state_next.blk[0].low_staged = i_wdata;
        end
        IDX_B1_HIGH:
        begin
          state_next.blk[0].high = i_wdata;
          state_next.blk[0].start_addr = {i_wdata, state_reg.blk[0].low_staged};
        end
        IDX_B1_LINES:
        begin
          state_next.lines1 = i_wdata;
        end
        IDX_B2_LOW:
        begin
          state_next.blk[1].low_staged = i_wdata;
        end
        IDX_B2_HIGH:
        begin
          state_next.blk[1].high = i_wdata;
          state_next.blk[1].start_addr = {i_wdata, state_reg.blk[1].low_staged};
        end
        IDX_B2_LINES:
        begin
          state_next.lines2 = i_wdata;
        end
        IDX_B3_LOW:
        begin
          state_next.blk[2].low_staged = i_wdata;
        end
        IDX_B3_HIGH:
        begin
          state_next.blk[2].high = i_wdata;
          state_next.blk[2].start_addr = {i_wdata, state_reg.blk[2].low_staged};
        end
        IDX_B4_LOW:
        begin
          state_next.blk[3].low_staged = i_wdata;
        end
        IDX_B4_HIGH:
        begin
          state_next.blk[3].high = i_wdata;
          state_next.blk[3].start_addr = {i_wdata, state_reg.blk[3].low_staged};
        end
        default:
        begin
          // Indices outside the group are ignored
        end
      endcase
    end

    // Read data is registered; unmapped indices read zero
    // A read in the cycle of a write to the same index returns the old value
    if (i_rd)
    begin
      case (i_index)
        IDX_B1_LOW:
        begin
          state_next.rdata = state_reg.blk[0].low_staged;
        end
        IDX_B1_HIGH:
        begin
          state_next.rdata = state_reg.blk[0].high;
        end
        IDX_B1_LINES:
        begin
          state_next.rdata = state_reg.lines1;
        end
        IDX_B2_LOW:
        begin
          state_next.rdata = state_reg.blk[1].low_staged;
        end
        IDX_B2_HIGH:
        begin
          state_next.rdata = state_reg.blk[1].high;
        end
        IDX_B2_LINES:
        begin
          state_next.rdata = state_reg.lines2;
        end
        IDX_B3_LOW:
        begin
          state_next.rdata = state_reg.blk[2].low_staged;
        end
        IDX_B3_HIGH:
        begin
          state_next.rdata = state_reg.blk[2].high;
        end
        IDX_B4_LOW:
        begin
          state_next.rdata = state_reg.blk[3].low_staged;
        end
        IDX_B4_HIGH:
        begin
          state_next.rdata = state_reg.blk[3].high;
        end
        default:
        begin
          state_next.rdata = REG_RESET;
        end
      endcase
    end
    // Heights are worked out a cycle early so the height outputs stay plain flip-flops
    state_next.lines1_count = 9'({1'b0, state_next.lines1} + LINE_COUNT_BIAS);
    state_next.lines2_count = 9'({1'b0, state_next.lines2} + LINE_COUNT_BIAS);
  end

  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      state_reg <= STATE_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs come directly from state flip-flops
  always_comb
  begin
    O_RDATA = state_reg.rdata;
    O_BLOCK1_START_ADDR = state_reg.blk[0].start_addr;
    O_BLOCK2_START_ADDR = state_reg.blk[1].start_addr;
    O_BLOCK3_START_ADDR = state_reg.blk[2].start_addr;
    O_BLOCK4_START_ADDR = state_reg.blk[3].start_addr;
    O_BLOCK1_LINES = state_reg.lines1_count;
    O_BLOCK2_LINES = state_reg.lines2_count;
    O_SCROLL_ACTIVE = (state_reg.intake == INTAKE_LOAD);
  end
endmodule

//--- tb/scroll_host.sv
// Host model: register writes, reads and scroll parameter lists.
// Assumes one clock; every change lands just after a rising edge.
`timescale 1ns/1ps
module scroll_host(
  input wire logic I_SYS_CLK,
  output logic i_wr = 1'b0,
  output logic i_rd = 1'b0,
  output logic i_scroll_cmd = 1'b0,
  output logic i_param_wr = 1'b0,
  output logic [7:0] i_index = 8'h00,
  output logic [7:0] i_wdata = 8'h00
);
  // One-cycle strobe; data inverted after release so stale bytes never look valid
  task automatic x(input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge I_SYS_CLK);
    {i_rd, i_wr, i_index, i_wdata} <= {r, !r, a, d};
    @(posedge I_SYS_CLK);
    {i_rd, i_wr, i_wdata} <= {2'b00, ~d};
  endtask
  // Bytes 0x40 onward, one a cycle, for indices 0x0B to 0x14
  task automatic scroll();
    @(posedge I_SYS_CLK);
    i_scroll_cmd <= 1'b1;
    @(posedge I_SYS_CLK);
    {i_scroll_cmd, i_param_wr} <= 2'b01;
    for (int k = 0; k < 10; k++)
    begin
      i_wdata <= 8'h40 + 8'(k);
      @(posedge I_SYS_CLK);
    end
    i_param_wr <= 1'b0;
  endtask
endmodule

//--- tb/scroll_regs_chk.sv
// Checker for the start address and line count group.
// Bound to scroll_regs; sees its ports only.
`timescale 1ns/1ps
module scroll_regs_chk(
  input wire logic I_SYS_CLK,
  input wire logic I_SYS_RST,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_scroll_cmd,
  input wire logic i_param_wr,
  input wire logic [7:0] i_index,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] O_RDATA,
  input wire logic [15:0] O_BLOCK1_START_ADDR,
  input wire logic [8:0] O_BLOCK1_LINES,
  input wire logic [8:0] O_BLOCK2_LINES,
  input wire logic O_SCROLL_ACTIVE
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);
  sequence s_wr(logic [7:0] a);
    i_wr && !i_scroll_cmd && !(O_SCROLL_ACTIVE && i_param_wr) && i_index == a;
  endsequence
  sequence s_param;
    i_param_wr && !i_scroll_cmd;
  endsequence
  sequence s_scroll_list;
    i_scroll_cmd ##1 s_param [*5] ##1 s_param [*5];
  endsequence
  a_low_held: assert property (s_wr(8'h0B) |=> $stable(O_BLOCK1_START_ADDR))
    else $error("low byte moved address");
  a_high_loads: assert property (s_wr(8'h0C) |=> O_BLOCK1_START_ADDR[15:8] == $past(i_wdata))
    else $error("high byte not applied");
  a_lines1_plus: assert property (s_wr(8'h0D) |=> O_BLOCK1_LINES == $past(i_wdata) + 9'h001)
    else $error("block 1 height wrong");
  a_lines2_plus: assert property (s_wr(8'h10) |=> O_BLOCK2_LINES == $past(i_wdata) + 9'h001)
    else $error("block 2 height wrong");
  a_scroll_opens: assert property (i_scroll_cmd |=> O_SCROLL_ACTIVE)
    else $error("scroll intake not open");
  a_scroll_closes: assert property (s_scroll_list |=> !O_SCROLL_ACTIVE)
    else $error("scroll intake left open after last parameter");
  a_rd_unmapped: assert property (i_rd && (i_index < 8'h0B || i_index > 8'h14) |=> O_RDATA == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind scroll_regs scroll_regs_chk u_chk(.*);

//--- tb/scroll_regs_test.sv
// Bench for scroll_regs: table of address writes, then reads, heights, scroll, reset.
// Assumes scroll_host drives every bus input.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module scroll_regs_test;
  import scroll_regs_pkg::*;
  logic I_SYS_CLK = 1'b0;
  logic I_SYS_RST = 1'b1;
  logic i_wr, i_rd, i_scroll_cmd, i_param_wr, O_SCROLL_ACTIVE;
  logic [7:0] i_index, i_wdata, O_RDATA;
  logic [15:0] O_BLOCK1_START_ADDR, O_BLOCK2_START_ADDR, O_BLOCK3_START_ADDR, O_BLOCK4_START_ADDR;
  logic [8:0] O_BLOCK1_LINES, O_BLOCK2_LINES;
  wire logic [63:0] sa = {O_BLOCK4_START_ADDR, O_BLOCK3_START_ADDR, O_BLOCK2_START_ADDR, O_BLOCK1_START_ADDR};
  int num_errors = 0;
  int cmp_count = 0;
  logic [23:0] rows [4] = '{24'h0B_1234, 24'h0E_ABCD, 24'h11_0F0F, 24'h13_FFFF};
  always #5 I_SYS_CLK = ~I_SYS_CLK;
  scroll_host host(.*);
  scroll_regs DUT(.*);
  task complete_run;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    num_errors++;
    complete_run;
  end
  initial
  begin
    repeat (20) @(posedge I_SYS_CLK);
    I_SYS_RST <= 1'b0;
    #1 `CHK(O_BLOCK1_LINES, 9'h001)
    foreach (rows[i])
    begin
      host.x(1'b0, rows[i][23:16], rows[i][7:0]);
      #1 `CHK(sa[i*16+:16], 16'h0000)
      host.x(1'b0, rows[i][23:16] + 8'h01, rows[i][15:8]);
      #1 `CHK(sa[i*16+:16], rows[i][15:0])
    end
    host.x(1'b1, 8'h0B, 8'h00);
    #1 `CHK(O_RDATA, 8'h34)
    host.x(1'b1, 8'h20, 8'h00);
    #1 `CHK(O_RDATA, 8'h00)
    host.x(1'b0, 8'h0D, 8'hFF);
    #1 `CHK(O_BLOCK1_LINES, 9'h100)
    host.x(1'b0, 8'h10, 8'h2A);
    #1 `CHK(O_BLOCK2_LINES, 9'h02B)
    host.scroll();
    #1 `CHK({O_SCROLL_ACTIVE, sa}, {1'b0, 64'h4948_4746_4443_4140})
    `CHK({O_BLOCK1_LINES, O_BLOCK2_LINES}, {9'h043, 9'h046})
    host.x(1'b1, 8'h0D, 8'h00);
    #1 `CHK(O_RDATA, 8'h42)
    @(posedge I_SYS_CLK);
    I_SYS_RST <= 1'b1;
    #1 `CHK(sa, 64'h0000_0000_0000_0000)
    `CHK({O_RDATA, O_BLOCK1_LINES, O_BLOCK2_LINES}, {8'h00, 9'h001, 9'h001})
    @(posedge I_SYS_CLK);
    I_SYS_RST <= 1'b0;
    host.x(1'b0, 8'h0C, 8'h5A);
    #1 `CHK(O_BLOCK1_START_ADDR, 16'h5A00)
    complete_run;
  end
endmodule
